// >>> hdl/ubmu_consts.svh
// Constants for the break match unit
//----------------------------------------------------------------
//----------------------------------------------------------------
`ifndef UBMU_CONSTS_SVH
`define UBMU_CONSTS_SVH

`define UBMU_OFF_ADDR  8'h00
`define UBMU_OFF_MASK  8'h04
`define UBMU_OFF_QUAL  8'h08
`define UBMU_OFF_STAT  8'h0C
`define UBMU_OFF_HIT   8'h10

`define UBMU_RST_WORD  32'h0000_0000
`define UBMU_QUAL_BITS 32'h0000_00FF

`define UBMU_CP_HI     7
`define UBMU_CP_LO     6
`define UBMU_ID_HI     5
`define UBMU_ID_LO     4
`define UBMU_RW_HI     3
`define UBMU_RW_LO     2
`define UBMU_SZ_HI     1
`define UBMU_SZ_LO     0

`define UBMU_ST_PEND   0
`define UBMU_ST_SECOND 1
`define UBMU_ST_DATA   2

`define UBMU_LEVEL     4'hF
`define UBMU_ACC_MAX   4'hE

`define UBMU_RESP_OK   2'h0
`define UBMU_RESP_ERR  2'h2

`endif

// >>> hdl/ubmu_pkg.sv
// Types for the break match unit
package ubmu_pkg;
    typedef logic [31:0] ubmu_word_t;
    typedef logic [7:0]  ubmu_addr_t;
    typedef logic [1:0]  ubmu_sel_t;
    typedef enum logic [1:0] {
        UBMU_SZ_ANY,
        UBMU_SZ_BYTE,
        UBMU_SZ_WORD,
        UBMU_SZ_LONG
    } ubmu_size_t;
    typedef enum logic [2:0] {
        UBMU_R_ADDR,
        UBMU_R_MASK,
        UBMU_R_QUAL,
        UBMU_R_STAT,
        UBMU_R_HIT,
        UBMU_R_NONE
    } ubmu_reg_t;
endpackage

// >>> hdl/ubmu_top.sv
// Break match unit with AXI4-Lite register slave
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ubmu_consts.svh"

module ubmu_top (
    // Clock and reset
    input  wire logic                MCLK,
    input  wire logic                RST_B,
    // AXI4-Lite slave
    input  wire ubmu_pkg::ubmu_addr_t S_AXI_AWADDR,
    input  wire logic                S_AXI_AWVALID,
    output logic                     S_AXI_AWREADY,
    input  wire ubmu_pkg::ubmu_word_t S_AXI_WDATA,
    input  wire logic [3:0]          S_AXI_WSTRB,
    input  wire logic                S_AXI_WVALID,
    output logic                     S_AXI_WREADY,
    output logic [1:0]               S_AXI_BRESP,
    output logic                     S_AXI_BVALID,
    input  wire logic                S_AXI_BREADY,
    input  wire ubmu_pkg::ubmu_addr_t S_AXI_ARADDR,
    input  wire logic                S_AXI_ARVALID,
    output logic                     S_AXI_ARREADY,
    output ubmu_pkg::ubmu_word_t     S_AXI_RDATA,
    output logic [1:0]               S_AXI_RRESP,
    output logic                     S_AXI_RVALID,
    input  wire logic                S_AXI_RREADY,
    // Observed bus cycle
    input  wire logic                BC_VALID,
    input  wire ubmu_pkg::ubmu_word_t BC_ADDR,
    input  wire logic                BC_PERIPH,
    input  wire logic                BC_FETCH,
    input  wire logic                BC_WRITE,
    input  wire ubmu_pkg::ubmu_size_t BC_SIZE,
    input  wire logic                BC_PAIR,
    // Interrupt controller side
    input  wire logic [3:0]          MASK_LEVEL,
    input  wire logic                BRK_ACK,
    output logic                     BRK_REQ,
    output logic                     BRK_ACCEPT,
    output logic [3:0]               BRK_LEVEL,
    output ubmu_pkg::ubmu_word_t     BRK_ADDR,
    output logic                     BRK_SECOND,
    output logic                     BRK_DATA
);
    import ubmu_pkg::*;

    //------------------------------------------------------------
    // Decode and match helpers
    //------------------------------------------------------------
    function automatic ubmu_reg_t reg_dec(input ubmu_addr_t a);
        case (a)
            `UBMU_OFF_ADDR: reg_dec = UBMU_R_ADDR;
            `UBMU_OFF_MASK: reg_dec = UBMU_R_MASK;
            `UBMU_OFF_QUAL: reg_dec = UBMU_R_QUAL;
            `UBMU_OFF_STAT: reg_dec = UBMU_R_STAT;
            `UBMU_OFF_HIT:  reg_dec = UBMU_R_HIT;
            default:        reg_dec = UBMU_R_NONE;
        endcase
    endfunction

    function automatic ubmu_word_t merge(input ubmu_word_t old,
                                         input ubmu_word_t wd,
                                         input logic [3:0] be);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                merge[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
    endfunction

    // One instruction or access against the programmed condition
    function automatic logic hit(input ubmu_word_t a,
                                 input logic per,
                                 input logic fet,
                                 input logic wr,
                                 input ubmu_size_t sz,
                                 input ubmu_word_t bar,
                                 input ubmu_word_t bam,
                                 input ubmu_word_t q);
        logic       a_ok;
        logic       cp_ok;
        logic       id_ok;
        logic       rw_ok;
        logic       sz_ok;
        ubmu_size_t eff;
        a_ok  = ((a ^ bar) & ~bam) == `UBMU_RST_WORD;
        cp_ok = per ? q[`UBMU_CP_HI] : q[`UBMU_CP_LO];
        // Peripheral cycles never fetch, fetches never write
        id_ok = (fet && !per) ? q[`UBMU_ID_LO] : q[`UBMU_ID_HI];
        rw_ok = (wr && !fet) ? q[`UBMU_RW_HI] : q[`UBMU_RW_LO];
        eff   = fet ? UBMU_SZ_WORD : sz;
        sz_ok = (q[`UBMU_SZ_HI:`UBMU_SZ_LO] == UBMU_SZ_ANY) ||
                (q[`UBMU_SZ_HI:`UBMU_SZ_LO] == eff);
        hit = a_ok && cp_ok && id_ok && rw_ok && sz_ok;
    endfunction

    //------------------------------------------------------------
    // Register bus slave
    //------------------------------------------------------------
    ubmu_word_t bar_r, bar_nxt;
    ubmu_word_t bam_r, bam_nxt;
    ubmu_word_t qual_r, qual_nxt;
    ubmu_addr_t awaddr_r, awaddr_nxt;
    ubmu_word_t wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic       aw_got_r, aw_got_nxt;
    logic       w_got_r, w_got_nxt;
    logic       awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
    logic [1:0] bresp_nxt, rresp_nxt;
    ubmu_word_t rdata_nxt;
    logic       wr_en;
    logic       soft_clr;
    ubmu_word_t stat_w;
    logic       pend_r, second_r, data_r;

    assign stat_w = {29'h0000_0000, data_r, second_r, pend_r};

    always_comb begin
        bar_nxt     = bar_r;
        bam_nxt     = bam_r;
        qual_nxt    = qual_r;
        awaddr_nxt  = awaddr_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = wstrb_r;
        aw_got_nxt  = aw_got_r;
        w_got_nxt   = w_got_r;
        bvalid_nxt  = S_AXI_BVALID && !S_AXI_BREADY;
        bresp_nxt   = S_AXI_BRESP;
        rvalid_nxt  = S_AXI_RVALID && !S_AXI_RREADY;
        rresp_nxt   = S_AXI_RRESP;
        rdata_nxt   = S_AXI_RDATA;
        wr_en       = 1'b0;
        soft_clr    = 1'b0;
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            awaddr_nxt = S_AXI_AWADDR;
            aw_got_nxt = 1'b1;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            wdata_nxt = S_AXI_WDATA;
            wstrb_nxt = S_AXI_WSTRB;
            w_got_nxt = 1'b1;
        end
        if (aw_got_r && w_got_r && !S_AXI_BVALID) begin
            wr_en      = 1'b1;
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = `UBMU_RESP_OK;
            case (reg_dec(awaddr_r))
                UBMU_R_ADDR: bar_nxt = merge(bar_r, wdata_r, wstrb_r);
                UBMU_R_MASK: bam_nxt = merge(bam_r, wdata_r, wstrb_r);
                UBMU_R_QUAL: qual_nxt = merge(qual_r, wdata_r, wstrb_r) & `UBMU_QUAL_BITS;
                UBMU_R_STAT: soft_clr = wstrb_r[0] && wdata_r[`UBMU_ST_PEND];
                UBMU_R_HIT:  bresp_nxt = `UBMU_RESP_OK;
                default:     bresp_nxt = `UBMU_RESP_ERR;
            endcase
        end
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = `UBMU_RESP_OK;
            case (reg_dec(S_AXI_ARADDR))
                UBMU_R_ADDR: rdata_nxt = bar_r;
                UBMU_R_MASK: rdata_nxt = bam_r;
                UBMU_R_QUAL: rdata_nxt = qual_r;
                UBMU_R_STAT: rdata_nxt = stat_w;
                UBMU_R_HIT:  rdata_nxt = BRK_ADDR;
                default: begin
                    rdata_nxt = `UBMU_RST_WORD;
                    rresp_nxt = `UBMU_RESP_ERR;
                end
            endcase
        end
        awready_nxt = !aw_got_nxt;
        wready_nxt  = !w_got_nxt;
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            bar_r         <= `UBMU_RST_WORD;
            bam_r         <= `UBMU_RST_WORD;
            qual_r        <= `UBMU_RST_WORD;
            awaddr_r      <= 8'h00;
            wdata_r       <= `UBMU_RST_WORD;
            wstrb_r       <= 4'h0;
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= `UBMU_RESP_OK;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RRESP   <= `UBMU_RESP_OK;
            S_AXI_RDATA   <= `UBMU_RST_WORD;
        end else begin
            bar_r         <= bar_nxt;
            bam_r         <= bam_nxt;
            qual_r        <= qual_nxt;
            awaddr_r      <= awaddr_nxt;
            wdata_r       <= wdata_nxt;
            wstrb_r       <= wstrb_nxt;
            aw_got_r      <= aw_got_nxt;
            w_got_r       <= w_got_nxt;
            S_AXI_AWREADY <= awready_nxt;
            S_AXI_WREADY  <= wready_nxt;
            S_AXI_BVALID  <= bvalid_nxt;
            S_AXI_BRESP   <= bresp_nxt;
            S_AXI_ARREADY <= arready_nxt;
            S_AXI_RVALID  <= rvalid_nxt;
            S_AXI_RRESP   <= rresp_nxt;
            S_AXI_RDATA   <= rdata_nxt;
        end
    end

    //------------------------------------------------------------
    // Match and pending request
    //------------------------------------------------------------
    ubmu_word_t addr2;
    logic       hit1, hit2, fire;
    logic       pend_nxt, second_nxt, data_nxt, accept_nxt;
    ubmu_word_t baddr_nxt;

    assign addr2 = {BC_ADDR[31:2], 2'b10};

    always_comb begin
        // Both halves of a pair judged against registers of this cycle
        hit1 = BC_VALID &&
               hit(BC_ADDR, BC_PERIPH, BC_FETCH, BC_WRITE, BC_SIZE, bar_r, bam_r, qual_r);
        hit2 = BC_VALID && BC_PAIR && BC_FETCH &&
               hit(addr2, BC_PERIPH, BC_FETCH, BC_WRITE, BC_SIZE, bar_r, bam_r, qual_r);
        fire       = hit1 || hit2;
        pend_nxt   = pend_r;
        second_nxt = second_r;
        data_nxt   = data_r;
        baddr_nxt  = BRK_ADDR;
        if (BRK_ACK || soft_clr) begin
            pend_nxt = 1'b0;
        end
        if (fire && !(pend_r && !BRK_ACK && !soft_clr)) begin
            pend_nxt   = 1'b1;
            second_nxt = !hit1;
            data_nxt   = !BC_FETCH;
            baddr_nxt  = hit1 ? BC_ADDR : addr2;
        end
        accept_nxt = pend_nxt && (MASK_LEVEL <= `UBMU_ACC_MAX);
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            pend_r     <= 1'b0;
            second_r   <= 1'b0;
            data_r     <= 1'b0;
            BRK_REQ    <= 1'b0;
            BRK_ACCEPT <= 1'b0;
            BRK_LEVEL  <= `UBMU_LEVEL;
            BRK_ADDR   <= `UBMU_RST_WORD;
            BRK_SECOND <= 1'b0;
            BRK_DATA   <= 1'b0;
        end else begin
            pend_r     <= pend_nxt;
            second_r   <= second_nxt;
            data_r     <= data_nxt;
            BRK_REQ    <= pend_nxt;
            BRK_ACCEPT <= accept_nxt;
            BRK_LEVEL  <= `UBMU_LEVEL;
            BRK_ADDR   <= baddr_nxt;
            BRK_SECOND <= second_nxt;
            BRK_DATA   <= data_nxt;
        end
    end

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    logic free;
    assign free = BC_VALID && !pend_r && !wr_en;

    a_zero_group: assert property ((free && (qual_r[`UBMU_CP_HI:`UBMU_CP_LO] == 2'b00 ||
        qual_r[`UBMU_ID_HI:`UBMU_ID_LO] == 2'b00 || qual_r[`UBMU_RW_HI:`UBMU_RW_LO] == 2'b00))
        |=> !BRK_REQ) else $error("break raised with a zero qualifier group");
    a_match_req: assert property ((free && hit1) |=> BRK_REQ ##0 BRK_ADDR == $past(BC_ADDR))
        else $error("matching cycle gave no request");
    a_level_const: assert property (BRK_LEVEL == 4'hF)
        else $error("break level is not fifteen");
    a_accept_mask: assert property (BRK_ACCEPT |-> BRK_REQ && $past(MASK_LEVEL) <= 4'hE)
        else $error("accepted above mask fourteen");
    a_hold_pend: assert property ((BRK_REQ && MASK_LEVEL == 4'hF && !BRK_ACK && !wr_en)
        |=> BRK_REQ && !BRK_ACCEPT) else $error("pending break dropped at mask fifteen");
    a_pair_second: assert property ((free && !hit1 && hit2)
        |=> BRK_SECOND && BRK_ADDR == {$past(BC_ADDR[31:2]), 2'b10})
        else $error("second instruction break misreported");
    a_fetch_pc: assert property ((free && BC_FETCH && hit1) |=> !BRK_DATA && !BRK_SECOND)
        else $error("fetch break flagged as data");
    a_fetch_write: assert property ((free && BC_FETCH &&
        qual_r[`UBMU_RW_HI:`UBMU_RW_LO] == 2'b10) |=> !BRK_REQ)
        else $error("fetch broke on write-only qualifier");
    a_periph_fetch: assert property ((free && BC_PERIPH &&
        qual_r[`UBMU_ID_HI:`UBMU_ID_LO] == 2'b01) |=> !BRK_REQ)
        else $error("peripheral cycle broke on fetch-only");
    a_word_odd: assert property ((free && !BC_FETCH && !BC_ADDR[0] && bar_r[0] && !bam_r[0])
        |=> !BRK_REQ) else $error("even access matched odd break address");
    a_data_pc: assert property ((free && !BC_FETCH && hit1) |=> BRK_DATA)
        else $error("data break not flagged");

    c_fetch_break: cover property (free && BC_FETCH && hit1 ##1 BRK_ACCEPT);
    c_pair_break:  cover property (free && !hit1 && hit2);
    c_held_break:  cover property (BRK_REQ && MASK_LEVEL == 4'hF ##1 MASK_LEVEL <= 4'hE ##1 BRK_ACCEPT);
    c_data_break:  cover property (free && BC_PERIPH && !BC_FETCH && hit1);
endmodule

// >>> dv/ubmu_irq_model.sv
// Interrupt controller and CPU model answering break requests
`timescale 1ns/1ps

module ubmu_irq_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Break link
    input  wire logic        brk_accept,
    input  wire logic [3:0]  brk_level,
    input  wire logic [31:0] brk_addr,
    input  wire logic [3:0]  mask_in,
    output logic             brk_ack,
    output logic [3:0]       mask_level,
    output logic [31:0]      saved_pc,
    output logic [7:0]       taken
);
    logic [1:0] wait_r;

    assign mask_level = mask_in;

    // Slow CPU: three cycles before it enters the exception
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            brk_ack  <= 1'b0;
            wait_r   <= 2'h0;
            saved_pc <= 32'h0000_0000;
            taken    <= 8'h00;
        end else begin
            brk_ack <= 1'b0;
            if (brk_accept && !brk_ack && brk_level > mask_in) begin
                wait_r <= wait_r + 2'h1;
                if (wait_r == 2'h2) begin
                    brk_ack  <= 1'b1;
                    saved_pc <= brk_addr;
                    taken    <= taken + 8'h01;
                    wait_r   <= 2'h0;
                end
            end else begin
                wait_r <= 2'h0;
            end
        end
    end
endmodule

// >>> dv/ubmu_test.sv
// Self-checking bench for the break match unit
`timescale 1ns/1ps
`include "ubmu_consts.svh"

module ubmu_test;
    import ubmu_pkg::*;
    logic       mclk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic       bc_valid, bc_periph, bc_fetch, bc_write, bc_pair, brk_ack, brk_req, brk_accept, brk_second, brk_data;
    ubmu_addr_t awaddr, araddr;
    ubmu_word_t wdata, rdata, bc_addr, brk_addr, saved_pc;
    ubmu_size_t bc_size;
    logic [3:0] wstrb, mask_in, mask_level, brk_level;
    logic [1:0] bresp, rresp;
    logic [7:0] taken;
    logic [7:0] q_off[3] = '{8'h14, 8'h44, 8'h50};
    int         err_total = 0, samples_checked = 0, cycles = 0, n;

    ubmu_top ubmu_top_i (.MCLK(mclk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .BC_VALID(bc_valid),
        .BC_ADDR(bc_addr), .BC_PERIPH(bc_periph), .BC_FETCH(bc_fetch), .BC_WRITE(bc_write),
        .BC_SIZE(bc_size), .BC_PAIR(bc_pair), .MASK_LEVEL(mask_level), .BRK_ACK(brk_ack),
        .BRK_REQ(brk_req), .BRK_ACCEPT(brk_accept), .BRK_LEVEL(brk_level), .BRK_ADDR(brk_addr),
        .BRK_SECOND(brk_second), .BRK_DATA(brk_data));

    ubmu_irq_model ubmu_irq_model_i (.clk(mclk), .rst_b(rst_b), .brk_accept(brk_accept), .brk_level(brk_level),
        .brk_addr(brk_addr), .mask_in(mask_in), .brk_ack(brk_ack), .mask_level(mask_level),
        .saved_pc(saved_pc), .taken(taken));

    always #25 mclk = ~mclk;

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // ----------------------------------------------------------------
    // Register bus master
    // ----------------------------------------------------------------
    task automatic wr(input ubmu_addr_t a, input ubmu_word_t d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", bresp, er);
        @(posedge mclk);
    endtask

    task automatic rd(input ubmu_addr_t a, input ubmu_word_t ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk("rdata", rdata, ed);
        chk("rresp", rresp, er);
        @(posedge mclk);
    endtask

    // ----------------------------------------------------------------
    // Program a condition, present one bus cycle, check the answer
    // ----------------------------------------------------------------
    task automatic row(input ubmu_word_t bar, bam, input logic [7:0] q, input ubmu_word_t ca,
                       input logic per, fet, w, input ubmu_size_t sz, input logic pr,
                       input logic ex, input ubmu_word_t ea, input logic es);
        wr(`UBMU_OFF_STAT, 32'h0000_0001, `UBMU_RESP_OK);
        wr(`UBMU_OFF_ADDR, bar, `UBMU_RESP_OK);
        wr(`UBMU_OFF_MASK, bam, `UBMU_RESP_OK);
        wr(`UBMU_OFF_QUAL, {24'h00_0000, q}, `UBMU_RESP_OK);
        bc_addr <= ca;
        bc_periph <= per;
        bc_fetch <= fet;
        bc_write <= w;
        bc_size <= sz;
        bc_pair <= pr;
        bc_valid <= 1'b1;
        @(posedge mclk);
        bc_valid <= 1'b0;
        #1;
        chk("brk_req", brk_req, ex);
        if (ex) begin
            chk("brk_addr", brk_addr, ea);
            chk("brk_second", brk_second, es);
            chk("brk_data", brk_data, !fet);
        end
        @(posedge mclk);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        mclk = 0;
        rst_b = 0;
        {awvalid, wvalid, bready, arvalid, rready, bc_valid, bc_periph, bc_fetch, bc_write, bc_pair} = '0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        bc_addr = 32'h0000_0000;
        bc_size = UBMU_SZ_ANY;
        wstrb = 4'hF;
        mask_in = 4'hF;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);
        for (n = 0; n < 5; n++)
            rd(8'(4 * n), 32'h0000_0000, `UBMU_RESP_OK);
        wr(`UBMU_OFF_QUAL, 32'hFFFF_FFFF, `UBMU_RESP_OK);
        rd(`UBMU_OFF_QUAL, 32'h0000_00FF, `UBMU_RESP_OK);
        wr(8'h14, 32'h1234_5678, `UBMU_RESP_ERR);
        rd(8'h14, 32'h0000_0000, `UBMU_RESP_ERR);
        // All three groups set in every enabling row below
        row(32'h0000_0404, 0, 8'h54, 32'h0000_0404, 0, 1, 0, UBMU_SZ_WORD, 0, 1, 32'h0000_0404, 0);
        chk("brk_accept", brk_accept, 0);
        chk("brk_level", brk_level, 4'hF);
        repeat (6) @(posedge mclk);
        chk("pending", brk_req, 1);
        mask_in <= 4'hE;
        for (n = 0; n < 20 && taken == 8'h00; n++)
            @(posedge mclk);
        chk("saved_pc", saved_pc, 32'h0000_0404);
        chk("taken", taken, 1);
        @(posedge mclk);
        chk("acked", brk_req, 0);
        mask_in <= 4'hF;
        row(32'h0015_389C, 0, 8'h58, 32'h0015_389C, 0, 1, 0, UBMU_SZ_WORD, 0, 0, 0, 0);
        row(32'h0015_389C, 0, 8'h58, 32'h0015_389C, 0, 1, 1, UBMU_SZ_WORD, 0, 0, 0, 0);
        row(32'h0003_0147, 0, 8'h54, 32'h0003_0146, 0, 1, 0, UBMU_SZ_WORD, 0, 0, 0, 0);
        row(32'h0003_0147, 0, 8'h54, 32'h0003_0147, 0, 1, 0, UBMU_SZ_WORD, 0, 1, 32'h0003_0147, 0);
        row(32'h0012_3456, 0, 8'h6A, 32'h0012_3456, 0, 0, 1, UBMU_SZ_WORD, 0, 1, 32'h0012_3456, 0);
        rd(`UBMU_OFF_STAT, 32'h0000_0005, `UBMU_RESP_OK);
        row(32'h0012_3456, 0, 8'h6A, 32'h0012_3456, 0, 0, 1, UBMU_SZ_BYTE, 0, 0, 0, 0);
        row(32'h00A8_0391, 0, 8'h66, 32'h00A8_0390, 0, 0, 0, UBMU_SZ_WORD, 0, 0, 0, 0);
        row(32'h0076_BCDC, 0, 8'hA7, 32'h0076_BCDC, 1, 0, 0, UBMU_SZ_LONG, 0, 1, 32'h0076_BCDC, 0);
        row(32'h0076_BCDC, 0, 8'hA7, 32'h0076_BCDC, 0, 0, 0, UBMU_SZ_LONG, 0, 0, 0, 0);
        row(32'h0023_45C8, 0, 8'h94, 32'h0023_45C8, 1, 0, 0, UBMU_SZ_WORD, 0, 0, 0, 0);
        row(32'h0023_45C8, 0, 8'h94, 32'h0023_45C8, 0, 1, 0, UBMU_SZ_WORD, 0, 0, 0, 0);
        row(32'h0023_45C8, 0, 8'h94, 32'h0023_45C8, 1, 1, 0, UBMU_SZ_WORD, 0, 0, 0, 0);
        foreach (q_off[i])
            row(32'h0000_0404, 0, q_off[i], 32'h0000_0404, 0, 1, 0, UBMU_SZ_WORD, 0, 0, 0, 0);
        row(32'h0000_0808, 0, 8'hFC, 32'h0000_0808, 1, 0, 1, UBMU_SZ_LONG, 0, 1, 32'h0000_0808, 0);
        row(32'h0000_0808, 0, 8'hFC, 32'h0000_0808, 0, 1, 0, UBMU_SZ_WORD, 0, 1, 32'h0000_0808, 0);
        row(32'h0000_1000, 32'h00FF, 8'h54, 32'h0000_10F0, 0, 1, 0, UBMU_SZ_WORD, 0, 1, 32'h0000_10F0, 0);
        row(32'h0000_1000, 32'h0000_00FF, 8'h54, 32'h0000_1100, 0, 1, 0, UBMU_SZ_WORD, 0, 0, 0, 0);
        row(32'h0000_2002, 0, 8'h54, 32'h0000_2000, 0, 1, 0, UBMU_SZ_WORD, 1, 1, 32'h0000_2002, 1);
        rd(`UBMU_OFF_STAT, 32'h0000_0003, `UBMU_RESP_OK);
        rd(`UBMU_OFF_HIT, 32'h0000_2002, `UBMU_RESP_OK);
        row(32'h0000_2000, 0, 8'h54, 32'h0000_2000, 0, 1, 0, UBMU_SZ_WORD, 1, 1, 32'h0000_2000, 0);
        row(32'h0000_0404, 0, 8'h56, 32'h0000_0404, 0, 1, 0, UBMU_SZ_BYTE, 0, 1, 32'h0000_0404, 0);
        row(32'h0000_0404, 0, 8'h55, 32'h0000_0404, 0, 1, 0, UBMU_SZ_BYTE, 0, 0, 0, 0);
        report_and_stop();
    end
endmodule
